// ---- logic/sbs_pkg.sv ----
// shared constants and types of the pipelined burst static memory
package sbs_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int SBS_ADDR_W  = 19;        // 512k words
    localparam int SBS_LANES   = 4;         // byte lanes per word
    localparam int SBS_LANE_W  = 8;         // bits per lane
    localparam int SBS_DATA_W  = SBS_LANES * SBS_LANE_W;
    localparam int SBS_BURST_W = 2;         // four-beat burst position

    // ------------------------------------------------------------------
    // reset, load and step values
    // ------------------------------------------------------------------
    localparam logic [SBS_BURST_W-1:0] SBS_CNT_RST   = 2'h0;
    localparam logic [SBS_BURST_W-1:0] SBS_CNT_FIRST = 2'h1; // beat after an address load
    localparam logic [SBS_BURST_W-1:0] SBS_CNT_STEP  = 2'h1;
    localparam logic                   SBS_MODE_RST  = 1'b1; // interleaved, as when floating
    localparam logic                   SBS_SLEEP_RST = 1'b0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SBS_DESEL  = 2'b00,                 // power-down, no burst
        SBS_ACTIVE = 2'b01,                 // selected, burst running
        SBS_SLEEP  = 2'b10                  // sleep request seen
    } sbs_state_t;

    // synchronous control lines from the memory controller
    typedef struct packed {
        logic [SBS_ADDR_W-1:0] address_in;
        logic                  chip_select_n;
        logic                  address_strobe_n;
        logic                  byte_write_master_n;
        logic [SBS_LANES-1:0]  lane_write_n;    // lane0_write_n in bit 0
    } sbs_cmd_t;

endpackage : sbs_pkg

// ---- logic/sbs_burst_addr.sv ----
// low address bits of a four-beat burst, linear or interleaved
module sbs_burst_addr
    import sbs_pkg::*;
(
    // burst position
    input  wire logic [SBS_BURST_W-1:0] start_low,
    input  wire logic [SBS_BURST_W-1:0] beat,
    input  wire logic                   interleaved,
    // result
    output logic      [SBS_BURST_W-1:0] addr_low
);

    // ------------------------------------------------------------------
    // order select
    // ------------------------------------------------------------------
    // the sum wraps inside two bits, so upper address bits never move
    always_comb
    begin
        if (interleaved)
            addr_low = start_low ^ beat;
        else
            addr_low = start_low + beat;
    end

endmodule : sbs_burst_addr

// ---- logic/sbs_sram.sv ----
// pipelined burst static memory, 32-bit word in four byte lanes
//
// Contract
// - address, data, select, strobe, write controls registered on rising edge
// - array of 512k words of 32 bits, four byte lanes on data bus
// - write only with master strobe low and any lane strobe low
// - only lanes with low write strobe are updated
// - address strobe low abandons burst, loads address, starts access if selected
// - address strobe low with select high deselects and starts no read; a read from the cycle before still drives the bus
// - chip select only sampled on address load cycles
// - address strobe high accesses the current internal burst address
// - order select low linear, high interleaved, held static by host
// - interleaved beat address is start low bits xor beat number
// - linear beat address adds beat number to low bits, modulo four
// - read data driven only while output enable low, asynchronously
// - data bus floats from power-up until a read is done
// - each write stores one to four bytes captured on the edge
// - output enable low drives nothing until registered read data is valid
// - inputs are sampled again from the third rising edge after sleep release
module sbs_sram
    import sbs_pkg::*;
#(
    parameter int ADDR_W = SBS_ADDR_W
)
(
    // clock, reset, enable
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    // synchronous controls from the host
    input  wire sbs_pkg::sbs_cmd_t       cmd,
    input  wire logic [SBS_DATA_W-1:0]   data_in,
    // static and asynchronous pins
    input  wire logic                    burst_interleaved,
    input  wire logic                    output_enable_n,
    input  wire logic                    sleep_request,
    // data bus drive side
    output logic      [SBS_DATA_W-1:0]   data_out,
    output logic      [SBS_LANES-1:0]    data_oe,
    // status
    output logic                         power_down
);

    import sbs_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    sbs_state_t               state_r;
    sbs_state_t               state_nxt;
    logic [ADDR_W-1:0]        base_r;
    logic [ADDR_W-1:0]        base_nxt;
    logic [SBS_BURST_W-1:0]   cnt_r;
    logic [SBS_BURST_W-1:0]   cnt_nxt;
    logic                     rd_pend_r;
    logic                     rd_pend_nxt;
    logic [ADDR_W-1:0]        rd_addr_r;
    logic [ADDR_W-1:0]        rd_addr_nxt;
    logic                     rd_valid_r;
    logic                     rd_valid_nxt;
    logic [SBS_DATA_W-1:0]    rdata_r;
    logic [SBS_DATA_W-1:0]    rdata_nxt;
    logic                     pd_r;
    logic                     pd_nxt;
    logic                     sleep_meta_r;
    logic                     sleep_sync_r;
    logic                     mode_meta_r;
    logic                     mode_sync_r;
    logic [SBS_BURST_W-1:0]   burst_low;
    logic [ADDR_W-1:0]        eff_addr;
    logic                     load;
    logic                     selected;
    logic                     is_write;
    logic                     access;
    logic                     wr_en;
    logic [SBS_DATA_W-1:0]    mem_word;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // the sleep pin enters the clocked logic only through two stages, so
    // input gating starts and ends at most two edges after the pin moves
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleep_meta_r <= SBS_SLEEP_RST;
            sleep_sync_r <= SBS_SLEEP_RST;
            mode_meta_r  <= SBS_MODE_RST;
            mode_sync_r  <= SBS_MODE_RST;
        end
        else if (clk_en)
        begin
            sleep_meta_r <= sleep_request;
            sleep_sync_r <= sleep_meta_r;
            mode_meta_r  <= burst_interleaved;
            mode_sync_r  <= mode_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // burst address
    // ------------------------------------------------------------------
    sbs_burst_addr u_burst (
        .start_low   (base_r[SBS_BURST_W-1:0]),
        .beat        (cnt_r),
        .interleaved (mode_sync_r),
        .addr_low    (burst_low)
    );

    // decode of the cycle sampled at this edge
    always_comb
    begin
        load     = !cmd.address_strobe_n && !sleep_sync_r;
        // select counts only when a new address is loaded
        selected = load ? !cmd.chip_select_n : (state_r == SBS_ACTIVE);
        is_write = !cmd.byte_write_master_n && !(&cmd.lane_write_n);
        access   = selected && !sleep_sync_r;
        wr_en    = access && is_write;
        if (load)
            eff_addr = cmd.address_in[ADDR_W-1:0];
        else
            eff_addr = {base_r[ADDR_W-1:SBS_BURST_W], burst_low};
    end

    // ------------------------------------------------------------------
    // cycle control
    // ------------------------------------------------------------------
    always_comb
    begin
        state_nxt   = state_r;
        base_nxt    = base_r;
        cnt_nxt     = cnt_r;
        rd_pend_nxt = access && !is_write;
        rd_addr_nxt = rd_addr_r;
        if (sleep_sync_r)
        begin
            // in-flight accesses are dropped here; the host avoids this
            state_nxt = SBS_SLEEP;
        end
        else if (load)
        begin
            base_nxt = cmd.address_in[ADDR_W-1:0];
            if (cmd.chip_select_n)
            begin
                state_nxt = SBS_DESEL;
                cnt_nxt   = SBS_CNT_RST;
            end
            else
            begin
                state_nxt = SBS_ACTIVE;
                cnt_nxt   = SBS_CNT_FIRST;
            end
        end
        else if (state_r == SBS_SLEEP)
            state_nxt = SBS_DESEL;                       // wake up deselected
        else if (access)
            cnt_nxt = cnt_r + SBS_CNT_STEP;
        if (access && !is_write)
            rd_addr_nxt = eff_addr;
        pd_nxt = (state_nxt != SBS_ACTIVE);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= SBS_DESEL;
            base_r    <= '0;
            cnt_r     <= SBS_CNT_RST;
            rd_pend_r <= 1'b0;
            rd_addr_r <= '0;
            pd_r      <= 1'b1;
        end
        else if (clk_en)
        begin
            state_r   <= state_nxt;
            base_r    <= base_nxt;
            cnt_r     <= cnt_nxt;
            rd_pend_r <= rd_pend_nxt;
            rd_addr_r <= rd_addr_nxt;
            pd_r      <= pd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // storage array
    // ------------------------------------------------------------------
    // no reset on the array: contents survive reset and sleep alike
    generate
        for (genvar g = 0; g < SBS_LANES; g++)
        begin : g_lane
            logic [SBS_LANE_W-1:0] mem [DEPTH];

            always_ff @(posedge core_clk)
            begin
                // write data is taken on the same edge as the command
                if (clk_en && wr_en && !cmd.lane_write_n[g])
                    mem[eff_addr] <= data_in[g*SBS_LANE_W +: SBS_LANE_W];
            end

            assign mem_word[g*SBS_LANE_W +: SBS_LANE_W] = mem[rd_addr_r];
        end
    endgenerate

    // ------------------------------------------------------------------
    // read pipeline stage
    // ------------------------------------------------------------------
    // one register between array and pins, so data shows one edge late
    always_comb
    begin
        rd_valid_nxt = rd_pend_r && !sleep_sync_r;
        rdata_nxt    = rd_pend_r ? mem_word : rdata_r;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_valid_r <= 1'b0;
            rdata_r    <= '0;
        end
        else if (clk_en)
        begin
            rd_valid_r <= rd_valid_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // enable and sleep act on the drivers without a clock; a write after a
    // read relies on the host holding enable high over the data window
    assign data_oe    = {SBS_LANES{rd_valid_r && !output_enable_n
                                  && !sleep_request}};
    assign data_out   = rdata_r;
    assign power_down = pd_r;

endmodule : sbs_sram

// ---- verification/sbs_sram_checker.sv ----
// port assertions of the pipelined burst memory
module sbs_sram_checker
    import sbs_pkg::*;
#(
    parameter int ADDR_W = SBS_ADDR_W
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire sbs_cmd_t cmd,
    input wire logic [SBS_DATA_W-1:0] data_in,
    input wire logic burst_interleaved,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [SBS_DATA_W-1:0] data_out,
    input wire logic [SBS_LANES-1:0] data_oe,
    input wire logic power_down
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] slp_r, slp_nxt;
    logic seen_r, seen_nxt, calm, load, rd, acc;
    // inputs count only once the sleep synchroniser has drained
    assign calm = clk_en && !sleep_request && slp_r == 3'h0;
    assign load = calm && !cmd.address_strobe_n;
    assign rd = cmd.byte_write_master_n || &cmd.lane_write_n;
    assign acc = load ? !cmd.chip_select_n : calm && !power_down;
    always_comb
    begin
        slp_nxt = {slp_r[1:0], sleep_request};
        seen_nxt = seen_r || (acc && rd);
    end
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n) {slp_r, seen_r} <= 4'h0;
        else {slp_r, seen_r} <= {slp_nxt, seen_nxt};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence rd_load;
        load && !cmd.chip_select_n && rd;
    endsequence
    oe_gate_a: assert property (data_oe != 4'h0 |->
        !output_enable_n && !sleep_request)
        else $error("bus driven while disabled");
    lanes_even_a: assert property (data_oe == 4'h0 || data_oe == 4'hf)
        else $error("lane enables differ");
    powerup_float_a: assert property (!seen_r |-> data_oe == 4'h0)
        else $error("bus driven before any read");
    desel_a: assert property (load && cmd.chip_select_n |=> power_down)
        else $error("deselect not taken");
    select_a: assert property (load && !cmd.chip_select_n |=> !power_down)
        else $error("select not taken");
    cs_ignored_a: assert property (calm && cmd.address_strobe_n && power_down |=>
        power_down)
        else $error("select seen without load");
    read_lat_a: assert property (rd_load |-> ##2
        (data_oe == 4'hf || output_enable_n || sleep_request))
        else $error("read data not driven");
    write_quiet_a: assert property (acc && !rd |-> ##2 data_oe == 4'h0)
        else $error("write drove the bus");
endmodule : sbs_sram_checker
bind sbs_sram sbs_sram_checker #(.ADDR_W(ADDR_W)) i_chk (.core_clk(core_clk), .rst_n(rst_n),
    .clk_en(clk_en), .cmd(cmd), .data_in(data_in), .burst_interleaved(burst_interleaved),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .data_out(data_out), .data_oe(data_oe), .power_down(power_down));

// ---- verification/sbs_host.sv ----
// host controller model: one synchronous command per clock
module sbs_host
    import sbs_pkg::*;
(
    input wire logic core_clk,
    output sbs_cmd_t cmd,
    output logic [SBS_DATA_W-1:0] data_in,
    output logic output_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cmd = '{19'h0, 1'b1, 1'b1, 1'b1, 4'hf};
        data_in = 32'h0;
        output_enable_n = 1'b1;
    end
    // launched at a falling edge, held across the sampling rising edge
    task automatic issue(input logic s_n, input logic c_n, input logic [18:0] a,
        input logic w_n, input logic [3:0] l_n, input logic [31:0] d);
        logic wr;
        wr = !w_n && !(&l_n);
        cmd = '{a, c_n, s_n, w_n, l_n};
        data_in = wr ? d : ~data_in; // idle data lines never look stable
        output_enable_n = wr; // off around write data
        @(negedge core_clk);
    endtask : issue
endmodule : sbs_host

// ---- verification/testbench.sv ----
// self-checking bench of the burst memory driven through the host model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbs_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, mode = 1'b1, sleep_request = 1'b0, clk_en = 1'b1;
    sbs_cmd_t cmd;
    logic [31:0] data_in, data_out, w, ref_m [0:255];
    logic [3:0] data_oe, l;
    logic power_down, output_enable_n;
    logic [7:0] a;
    int seed = 32'h61043994, miscompares = 0, total_checks = 0, g, k;
    always #2 core_clk = ~core_clk;
    sbs_host i_host (.core_clk(core_clk), .cmd(cmd), .data_in(data_in),
        .output_enable_n(output_enable_n));
    sbs_sram #(.ADDR_W(8)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .cmd(cmd), .data_in(data_in), .burst_interleaved(mode),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .data_out(data_out), .data_oe(data_oe), .power_down(power_down));
    // low address bits of beat n
    function automatic logic [1:0] ba(input logic [1:0] s, input int n);
        return mode ? s ^ n[1:0] : s + n[1:0];
    endfunction : ba
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic idle(input logic c_n);
        i_host.issue(1'b1, c_n, 19'h0, 1'b1, 4'hf, 32'h0);
    endtask : idle
    // one read burst; data of a beat shows one clock after its access
    task automatic rd_burst(input logic [7:0] s);
        i_host.issue(1'b0, 1'b0, {11'h0, s}, 1'b1, 4'hf, 32'h0);
        for (int j = 1; j < 5; j++)
        begin
            idle(1'b0);
            chk(data_out, ref_m[{s[7:2], ba(s[1:0], j - 1)}]);
        end
    endtask : rd_burst
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        // fill every word with write bursts from random start beats
        for (g = 0; g < 64; g++)
        begin
            a = 8'($random(seed));
            for (k = 0; k < 4; k++)
            begin
                w = $random(seed);
                ref_m[{g[5:0], ba(a[1:0], k)}] = w;
                i_host.issue(k != 0, 1'b0, {11'h0, g[5:0], a[1:0]}, 1'b0, 4'h0, w);
            end
        end
        $display("test fill done");
        // both burst orders; mode moves only while deselected
        for (int m = 0; m < 2; m++)
        begin
            i_host.issue(1'b0, 1'b1, 19'h0, 1'b1, 4'hf, 32'h0);
            mode = m[0];
            repeat (3) i_host.issue(1'b1, 1'b0, 19'h0, 1'b0, 4'h0, 32'h0);
            chk({31'h0, power_down}, 32'h1);
            repeat (8) rd_burst(8'($random(seed)));
        end
        $display("test order done");
        // random lane masks, master strobe sometimes high
        repeat (24)
        begin
            a = 8'($random(seed));
            l = 4'($random(seed));
            w = $random(seed);
            g = $random(seed) & 1;
            for (k = 0; k < 4; k++)
                if (g == 0 && !l[k]) ref_m[a][8*k+:8] = w[8*k+:8];
            i_host.issue(1'b0, 1'b0, {11'h0, a}, g[0], l, w);
            rd_burst(a);
        end
        $display("test lanes done");
        // sleep after the last read has drained
        i_host.issue(1'b0, 1'b1, 19'h0, 1'b1, 4'hf, 32'h0);
        sleep_request = 1'b1;
        repeat (2) idle(1'b1);
        i_host.issue(1'b0, 1'b0, {11'h0, a}, 1'b0, 4'h0, ~ref_m[a]);
        i_host.issue(1'b0, 1'b0, {11'h0, a}, 1'b1, 4'hf, 32'h0);
        idle(1'b0);
        chk({28'h0, data_oe}, 32'h0);
        sleep_request = 1'b0;
        repeat (3) idle(1'b1);
        rd_burst(a);
        $display("test sleep done");
        // enable low freezes a running read burst and drops a write to its word
        i_host.issue(1'b0, 1'b0, {11'h0, a}, 1'b1, 4'hf, 32'h0);
        clk_en = 1'b0;
        repeat (2) i_host.issue(1'b0, 1'b0, {11'h0, a}, 1'b0, 4'h0, ~ref_m[a]);
        clk_en = 1'b1;
        for (k = 1; k < 5; k++)
        begin
            idle(1'b0);
            chk(data_out, ref_m[{a[7:2], ba(a[1:0], k - 1)}]);
        end
        $display("test freeze done");
        print_verdict();
    end
endmodule : testbench
